/* File: rtl/cmad_pkg.sv */
// constants, types and address map of the cpu memory access decoder
package cmad_pkg;
    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam logic [23:0] OPTION_BITS_ADDR = 24'h00_0000;
    localparam logic [23:0] RESET_VECTOR_ADDR = 24'h00_0004;
    localparam logic [23:0] SYSEXC_VECTOR_ADDR = 24'h00_0008;
    localparam logic [23:0] TRAP_VECTOR_ADDR = 24'h00_000C;
    localparam logic [23:0] IRQ_VECTOR_ADDR = 24'h00_0010;
    localparam logic [23:0] IRQ_VECTOR_LAST = 24'h00_006F;
    localparam logic [23:0] RAM_TOP = 24'hFF_BFFF;
    localparam logic [23:0] IO_BASE = 24'hFF_E000;
    localparam int IO_BYTES = 8192;
    localparam logic [23:0] CTRL_LAST = 24'hFF_E012;
    localparam int NVM_BYTES_DEF = 65536;
    localparam int RAM_BYTES_DEF = 4096;
    localparam logic [23:0] WIDE_PER_LO = 24'hFF_F000;
    localparam logic [23:0] WIDE_PER_HI = 24'hFF_FFFF;

    // ------------------------------------------------------------
    // cpu control registers
    // ------------------------------------------------------------
    localparam logic [23:0] PC_LIMIT_ADDR = 24'hFF_E004;
    localparam logic [23:0] SP_LIMIT_ADDR = 24'hFF_E00C;
    localparam logic [23:0] FLAGS_ADDR = 24'hFF_E010;
    localparam logic [23:0] CONTROL_ADDR = 24'hFF_E012;
    localparam logic [31:0] PC_LIMIT_RST = 32'h00FF_FFFF;
    localparam logic [31:0] SP_LIMIT_RST = 32'h0000_0000;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] BYTE_FILL = 8'hFF;
    localparam logic [15:0] LANE_FILL = 16'hFFFF;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_QUAD} cmad_size_t;
    typedef enum logic [2:0] {TGT_NONE, TGT_NVM, TGT_RAM, TGT_CTRL, TGT_PER} cmad_tgt_t;

    typedef struct packed {
        logic [23:0] addr;
        cmad_size_t size;
        logic write;
        logic [31:0] wdata;
    } cmad_req_t;

    // be[1] is the high lane (even byte), be[0] the low lane (odd byte)
    typedef struct packed {
        logic en;
        logic we;
        logic [1:0] be;
        logic [22:0] wordAddr;
        logic [15:0] wdata;
    } cmad_port_t;
endpackage

/* File: rtl/cmad_addr_decode.sv */
// address region decoder of the cpu memory access decoder
module cmad_addr_decode #(
    parameter int NVM_BYTES = cmad_pkg::NVM_BYTES_DEF,
    parameter int RAM_BYTES = cmad_pkg::RAM_BYTES_DEF,
    parameter logic [23:0] WIDE_LO = cmad_pkg::WIDE_PER_LO,
    parameter logic [23:0] WIDE_HI = cmad_pkg::WIDE_PER_HI
) (
    input wire logic [23:0] addr,
    output cmad_pkg::cmad_tgt_t tgt,
    output logic wide
);
    localparam int RAM_BOTTOM = int'(cmad_pkg::RAM_TOP) - RAM_BYTES + 1;

    if (NVM_BYTES < 2 || RAM_BYTES < 2 || NVM_BYTES > RAM_BOTTOM ||
        NVM_BYTES % 2 != 0 || RAM_BYTES % 2 != 0) begin : g_bad_sizes
        $error("cmad_addr_decode: memory sizes do not fit the address space");
    end

    // ------------------------------------------------------------
    // region decode
    // ------------------------------------------------------------
    always_comb begin
        tgt = cmad_pkg::TGT_NONE;
        wide = 1'b0;
        if (int'(addr) < NVM_BYTES) begin
            tgt = cmad_pkg::TGT_NVM;
            wide = 1'b1;
        end else if (int'(addr) >= RAM_BOTTOM && addr <= cmad_pkg::RAM_TOP) begin
            tgt = cmad_pkg::TGT_RAM;
            wide = 1'b1;
        end else if (addr >= cmad_pkg::IO_BASE &&
                     int'(addr) - int'(cmad_pkg::IO_BASE) < cmad_pkg::IO_BYTES) begin
            if (addr <= cmad_pkg::CTRL_LAST) begin
                tgt = cmad_pkg::TGT_CTRL;
            end else begin
                tgt = cmad_pkg::TGT_PER;
                wide = (addr >= WIDE_LO) && (addr <= WIDE_HI);
            end
        end
    end
endmodule

/* File: rtl/cmad_ctrl_regs.sv */
// cpu control registers at the base of the i/o region
module cmad_ctrl_regs (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic en,
    input wire logic we,
    input wire logic [23:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic hit,
    output logic [31:0] pcLimit,
    output logic [31:0] spLimit,
    output logic [7:0] cpuFlags,
    output logic [7:0] cpuControl
);
    typedef struct packed {
        logic [31:0] pcLimit;
        logic [31:0] spLimit;
        logic [7:0] flags;
        logic [7:0] control;
    } cmad_ctrl_state_t;

    cmad_ctrl_state_t s_r;
    cmad_ctrl_state_t s_nxt;

    // ------------------------------------------------------------
    // byte access, most significant byte at the lowest address
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        rdata = cmad_pkg::BYTE_FILL;
        hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (addr == cmad_pkg::PC_LIMIT_ADDR + 24'(i)) begin
                hit = 1'b1;
                rdata = s_r.pcLimit[8*(3-i) +: 8];
                if (en && we) begin
                    s_nxt.pcLimit[8*(3-i) +: 8] = wdata;
                end
            end
            if (addr == cmad_pkg::SP_LIMIT_ADDR + 24'(i)) begin
                hit = 1'b1;
                rdata = s_r.spLimit[8*(3-i) +: 8];
                if (en && we) begin
                    s_nxt.spLimit[8*(3-i) +: 8] = wdata;
                end
            end
        end
        if (addr == cmad_pkg::FLAGS_ADDR) begin
            hit = 1'b1;
            rdata = s_r.flags;
            if (en && we) begin
                s_nxt.flags = wdata;
            end
        end
        if (addr == cmad_pkg::CONTROL_ADDR) begin
            hit = 1'b1;
            rdata = s_r.control;
            if (en && we) begin
                s_nxt.control = wdata;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{cmad_pkg::PC_LIMIT_RST, cmad_pkg::SP_LIMIT_RST,
                     cmad_pkg::FLAGS_RST, cmad_pkg::CONTROL_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pcLimit = s_r.pcLimit;
    assign spLimit = s_r.spLimit;
    assign cpuFlags = s_r.flags;
    assign cpuControl = s_r.control;
endmodule

/* File: rtl/cmad_access_decoder.sv */
// top of the cpu memory access decoder: decode, split and sequence cpu accesses
module cmad_access_decoder #(
    parameter int NVM_BYTES = cmad_pkg::NVM_BYTES_DEF,
    parameter int RAM_BYTES = cmad_pkg::RAM_BYTES_DEF,
    parameter logic [23:0] WIDE_LO = cmad_pkg::WIDE_PER_LO,
    parameter logic [23:0] WIDE_HI = cmad_pkg::WIDE_PER_HI
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cpuReqValid,
    input wire cmad_pkg::cmad_req_t cpuReq,
    output logic cpuReady,
    output logic cpuDone,
    output logic [31:0] cpuRdata,
    output cmad_pkg::cmad_port_t nvmPort,
    input wire logic [15:0] nvmRdata,
    output cmad_pkg::cmad_port_t ramPort,
    input wire logic [15:0] ramRdata,
    output cmad_pkg::cmad_port_t perPort,
    input wire logic [15:0] perRdata,
    input wire logic perHit,
    output logic [31:0] pcLimit,
    output logic [31:0] spLimit,
    output logic [7:0] cpuFlags,
    output logic [7:0] cpuControl
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic {ST_IDLE, ST_ACCESS} cmad_state_t;

    typedef struct packed {
        cmad_state_t st;
        logic ready;
        logic done;
        logic [31:0] rdata;
        logic [23:0] cur;
        logic [2:0] rem;
        cmad_pkg::cmad_tgt_t tgt;
        logic [1:0] partBe;
        logic write;
        logic [31:0] wshift;
        logic [31:0] acc;
        cmad_pkg::cmad_port_t nvm;
        cmad_pkg::cmad_port_t ram;
        cmad_pkg::cmad_port_t per;
        logic ctrlEn;
        logic ctrlWe;
        logic [23:0] ctrlAddr;
        logic [7:0] ctrlWdata;
    } cmad_top_state_t;

    cmad_top_state_t s_r;
    cmad_top_state_t s_nxt;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] sizeBytes(input cmad_pkg::cmad_size_t size);
        case (size)
            cmad_pkg::SZ_BYTE: return 3'd1;
            cmad_pkg::SZ_WORD: return 3'd2;
            default: return 3'd4;
        endcase
    endfunction

    // left-align the operand so its most significant byte leaves first
    function automatic logic [31:0] alignWrite(input cmad_pkg::cmad_size_t size,
                                               input logic [31:0] data);
        case (size)
            cmad_pkg::SZ_BYTE: return {data[7:0], 24'h00_0000};
            cmad_pkg::SZ_WORD: return {data[15:0], 16'h0000};
            default: return data;
        endcase
    endfunction

    // an odd address always uses the low lane alone; narrow targets one lane
    function automatic logic [1:0] stepLanes(input logic odd, input logic [2:0] rem,
                                             input logic wide);
        if (odd) begin
            return 2'b01;
        end else if (wide && rem >= 3'd2) begin
            return 2'b11;
        end
        return 2'b10;
    endfunction

    cmad_pkg::cmad_tgt_t decTgt;
    logic decWide;
    logic [23:0] issAddr;
    logic [2:0] curCnt;
    logic [2:0] remLeft;
    logic accept;
    logic [15:0] capData;
    logic [7:0] ctrlRdata;
    logic ctrlHit;
    logic issue;
    logic [2:0] issRem;
    logic [31:0] issWs;
    logic [1:0] lanes;
    cmad_pkg::cmad_port_t issPort;

    assign accept = (s_r.st == ST_IDLE) && s_r.ready && cpuReqValid;
    assign curCnt = (s_r.partBe == 2'b11) ? 3'd2 : 3'd1;
    assign remLeft = s_r.rem - curCnt;
    // parts walk upward from the addressed byte
    assign issAddr = (s_r.st == ST_IDLE) ? cpuReq.addr : s_r.cur + 24'(curCnt);

    cmad_addr_decode #(
        .NVM_BYTES(NVM_BYTES),
        .RAM_BYTES(RAM_BYTES),
        .WIDE_LO(WIDE_LO),
        .WIDE_HI(WIDE_HI)
    ) u_decode (
        .addr(issAddr),
        .tgt(decTgt),
        .wide(decWide)
    );

    cmad_ctrl_regs u_ctrl (
        .clock(clock),
        .rst_n(rst_n),
        .en(s_r.ctrlEn),
        .we(s_r.ctrlWe),
        .addr(s_r.ctrlAddr),
        .wdata(s_r.ctrlWdata),
        .rdata(ctrlRdata),
        .hit(ctrlHit),
        .pcLimit(pcLimit),
        .spLimit(spLimit),
        .cpuFlags(cpuFlags),
        .cpuControl(cpuControl)
    );

    // ------------------------------------------------------------
    // read data of the part in flight, in lane format
    // ------------------------------------------------------------
    always_comb begin
        case (s_r.tgt)
            cmad_pkg::TGT_NVM: capData = nvmRdata;
            cmad_pkg::TGT_RAM: capData = ramRdata;
            cmad_pkg::TGT_PER: capData = perHit ? perRdata : cmad_pkg::LANE_FILL;
            cmad_pkg::TGT_CTRL: capData = ctrlHit ? {ctrlRdata, ctrlRdata}
                                                  : cmad_pkg::LANE_FILL;
            default: capData = cmad_pkg::LANE_FILL;
        endcase
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.nvm = '0;
        s_nxt.ram = '0;
        s_nxt.per = '0;
        s_nxt.ctrlEn = 1'b0;
        s_nxt.ctrlWe = 1'b0;
        issue = 1'b0;
        issRem = 3'd0;
        issWs = 32'h0000_0000;
        lanes = 2'b00;
        issPort = '0;
        case (s_r.st)
            ST_IDLE: begin
                s_nxt.ready = 1'b1;
                if (accept) begin
                    issue = 1'b1;
                    issRem = sizeBytes(cpuReq.size);
                    issWs = alignWrite(cpuReq.size, cpuReq.wdata);
                    s_nxt.write = cpuReq.write;
                    s_nxt.acc = 32'h0000_0000;
                    s_nxt.ready = 1'b0;
                end
            end
            ST_ACCESS: begin
                // earlier bytes shift up: big-endian assembly
                case (s_r.partBe)
                    2'b11: s_nxt.acc = {s_r.acc[15:0], capData};
                    2'b10: s_nxt.acc = {s_r.acc[23:0], capData[15:8]};
                    default: s_nxt.acc = {s_r.acc[23:0], capData[7:0]};
                endcase
                if (remLeft == 3'd0) begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.done = 1'b1;
                    s_nxt.ready = 1'b1;
                    s_nxt.rdata = s_nxt.acc;
                end else begin
                    issue = 1'b1;
                    issRem = remLeft;
                    if (s_r.partBe == 2'b11) begin
                        issWs = {s_r.wshift[15:0], 16'h0000};
                    end else begin
                        issWs = {s_r.wshift[23:0], 8'h00};
                    end
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
        if (issue) begin
            lanes = stepLanes(issAddr[0], issRem, decWide);
            issPort.en = 1'b1;
            issPort.we = s_nxt.write;
            issPort.be = lanes;
            issPort.wordAddr = issAddr[23:1];
            // a single byte is copied onto both lanes; the enables pick one
            if (lanes == 2'b11) begin
                issPort.wdata = issWs[31:16];
            end else begin
                issPort.wdata = {issWs[31:24], issWs[31:24]};
            end
            s_nxt.st = ST_ACCESS;
            s_nxt.cur = issAddr;
            s_nxt.rem = issRem;
            s_nxt.tgt = decTgt;
            s_nxt.partBe = lanes;
            s_nxt.wshift = issWs;
            case (decTgt)
                cmad_pkg::TGT_NVM: s_nxt.nvm = issPort;
                cmad_pkg::TGT_RAM: s_nxt.ram = issPort;
                cmad_pkg::TGT_PER: s_nxt.per = issPort;
                cmad_pkg::TGT_CTRL: begin
                    s_nxt.ctrlEn = 1'b1;
                    s_nxt.ctrlWe = s_nxt.write;
                    s_nxt.ctrlAddr = issAddr;
                    s_nxt.ctrlWdata = issWs[31:24];
                end
                // unmapped: no strobe leaves the block, so a write is lost
                default: s_nxt.ctrlEn = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cpuReady = s_r.ready;
    assign cpuDone = s_r.done;
    assign cpuRdata = s_r.rdata;
    assign nvmPort = s_r.nvm;
    assign ramPort = s_r.ram;
    assign perPort = s_r.per;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic memEn;
    logic [1:0] memBe;
    logic reqMem;
    logic reqOdd;
    assign memEn = s_r.nvm.en | s_r.ram.en;
    assign memBe = s_r.nvm.be | s_r.ram.be;
    assign reqMem = (decTgt == cmad_pkg::TGT_NVM) || (decTgt == cmad_pkg::TGT_RAM);
    assign reqOdd = cpuReq.addr[0];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_word_even: assert property (
        accept && reqMem && !reqOdd && cpuReq.size == cmad_pkg::SZ_WORD
        |-> ##1 (memEn && memBe == 2'b11) ##1 (cpuDone && !memEn))
        else $error("aligned word did not finish in one access");

    a_quad_even: assert property (
        accept && reqMem && !reqOdd && cpuReq.size == cmad_pkg::SZ_QUAD
        |-> ##1 memEn[*2] ##1 (cpuDone && !memEn))
        else $error("aligned quad did not finish in two accesses");

    a_word_odd: assert property (
        accept && reqMem && reqOdd && cpuReq.size == cmad_pkg::SZ_WORD
        |-> ##1 memEn[*2] ##1 (cpuDone && !memEn))
        else $error("odd word did not finish in two accesses");

    a_quad_odd: assert property (
        accept && reqMem && reqOdd && cpuReq.size == cmad_pkg::SZ_QUAD
        |-> ##1 memEn[*3] ##1 (cpuDone && !memEn))
        else $error("odd quad did not finish in three accesses");

    a_odd_lanes: assert property (
        accept && reqMem && reqOdd && cpuReq.size != cmad_pkg::SZ_BYTE
        |=> memBe == 2'b01 ##1 memBe != 2'b01)
        else $error("odd access used the wrong byte lanes");

    a_stall_cpu: assert property (
        cpuDone |-> cpuReady && !$past(cpuReady))
        else $error("result returned while the cpu was not stalled");

    a_unmapped_read: assert property (
        accept && decTgt == cmad_pkg::TGT_NONE && !cpuReq.write &&
        cpuReq.size == cmad_pkg::SZ_BYTE
        |-> ##2 (cpuDone && cpuRdata[7:0] == cmad_pkg::BYTE_FILL))
        else $error("unmapped read did not return FF");

    a_dropped_write: assert property (
        accept && decTgt == cmad_pkg::TGT_NONE && cpuReq.write
        |=> !memEn && !s_r.per.en && !s_r.ctrlEn)
        else $error("unmapped write reached a target");

    a_ram_top: assert property (
        issAddr == cmad_pkg::RAM_TOP |-> decTgt == cmad_pkg::TGT_RAM)
        else $error("top ram address not decoded as ram");

    a_io_region: assert property (
        issAddr >= cmad_pkg::IO_BASE
        |-> decTgt == cmad_pkg::TGT_CTRL || decTgt == cmad_pkg::TGT_PER)
        else $error("i/o address not decoded to the i/o region");
endmodule

/* File: testbench/cmad_mem_model.sv */
// far-side model of one 16-bit memory or peripheral target
module cmad_mem_model #(
    parameter logic [7:0] SALT = 8'hA5,
    parameter logic [22:0] HIT_LO = 23'h00_0000,
    parameter logic [22:0] HIT_HI = 23'h7F_FFFF
) (
    input wire logic clock,
    input wire cmad_pkg::cmad_port_t port,
    output logic [15:0] rdata,
    output logic hit
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256];
    logic [7:0] hiIdx;
    logic [7:0] loIdx;
    assign hiIdx = {port.wordAddr[6:0], 1'b0};
    assign loIdx = {port.wordAddr[6:0], 1'b1};
    // idle bus shows the inverse, so stale data never passes
    assign rdata = port.en ? {mem[hiIdx], mem[loIdx]} : ~{mem[hiIdx], mem[loIdx]};
    assign hit = port.en && port.wordAddr >= HIT_LO && port.wordAddr <= HIT_HI;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ SALT;
        end
    end
    always @(posedge clock) begin
        if (port.en && port.we && hit) begin
            if (port.be[1]) begin
                mem[hiIdx] <= port.wdata[15:8];
            end
            if (port.be[0]) begin
                mem[loIdx] <= port.wdata[7:0];
            end
        end
    end
    function automatic logic [7:0] peek(input logic [7:0] a);
        return mem[a];
    endfunction
endmodule

/* File: testbench/cpu_memory_access_decoder_tb_top.sv */
// self-checking bench of the cpu memory access decoder
module cpu_memory_access_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cpuReqValid = 1'b0;
    cmad_pkg::cmad_req_t cpuReq = '0;
    logic cpuReady, cpuDone, perHit, nvmHit, ramHit;
    logic [31:0] cpuRdata, pcLimit, spLimit, rd;
    logic [7:0] cpuFlags, cpuControl, beLog;
    cmad_pkg::cmad_port_t nvmPort, ramPort, perPort;
    logic [15:0] nvmRdata, ramRdata, perRdata;
    int nErrors = 0;
    int comparisons = 0;
    int nStrobe = 0;
    int lat;
    always #50 clock = ~clock;

    cmad_access_decoder cmad_access_decoder_inst (.clock(clock),
        .rst_n(rst_n), .cpuReqValid(cpuReqValid), .cpuReq(cpuReq), .cpuReady(cpuReady),
        .cpuDone(cpuDone), .cpuRdata(cpuRdata), .nvmPort(nvmPort), .nvmRdata(nvmRdata),
        .ramPort(ramPort), .ramRdata(ramRdata), .perPort(perPort), .perRdata(perRdata),
        .perHit(perHit), .pcLimit(pcLimit), .spLimit(spLimit), .cpuFlags(cpuFlags),
        .cpuControl(cpuControl));
    cmad_mem_model cmad_mem_model_inst_nvm (.clock(clock), .port(nvmPort),
        .rdata(nvmRdata), .hit(nvmHit));
    cmad_mem_model #(.SALT(8'h3C)) cmad_mem_model_inst_ram (.clock(clock), .port(ramPort),
        .rdata(ramRdata), .hit(ramHit));
    cmad_mem_model #(.SALT(8'h69), .HIT_LO(23'h7F_F080), .HIT_HI(23'h7F_F0FF))
        cmad_mem_model_inst_per (.clock(clock), .port(perPort), .rdata(perRdata), .hit(perHit));

    always @(negedge clock) begin
        if ((nvmPort.en && nvmHit) || (ramPort.en && ramHit) || perPort.en) begin
            nStrobe++;
            beLog = {beLog[5:0], (nvmPort.en ? nvmPort.be : 2'h0) | (ramPort.en ? ramPort.be : 2'h0)
                | (perPort.en ? perPort.be : 2'h0)};
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            nErrors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic acc(input logic [23:0] a, input cmad_pkg::cmad_size_t sz, input logic wr,
                       input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clock);
        cpuReqValid <= 1'b1;
        cpuReq <= '{addr: a, size: sz, write: wr, wdata: wd};
        @(negedge clock);
        while (cpuReady !== 1'b1 && k < 50) begin
            @(negedge clock);
            k++;
        end
        @(posedge clock);
        cpuReqValid <= 1'b0;
        nStrobe = 0;
        beLog = 8'h00;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (cpuDone !== 1'b1 && k < 50);
        rd = cpuRdata;
        lat = k - 1;
        if (cpuDone !== 1'b1) begin
            nErrors++;
            $display("Error cpuDone expected 1 seen %b", cpuDone);
        end
    endtask

    // expected lanes and part count, worked out from alignment
    function automatic logic [11:0] exp_be(input logic [23:0] a, input int n);
        logic [7:0] log;
        int cnt;
        log = 8'h00;
        cnt = 0;
        while (n > 0) begin
            if (a[0]) begin
                log = {log[5:0], 2'b01};
                n -= 1;
                a += 1;
            end else if (n >= 2) begin
                log = {log[5:0], 2'b11};
                n -= 2;
                a += 2;
            end else begin
                log = {log[5:0], 2'b10};
                n -= 1;
            end
            cnt++;
        end
        return {4'(cnt), log};
    endfunction

    function automatic logic [31:0] exp_rd(input logic [7:0] salt, input logic [23:0] a,
                                           input int n);
        logic [31:0] v;
        v = '0;
        for (int i = 0; i < n; i++) begin
            v = {v[23:0], 8'(a + 24'(i)) ^ salt};
        end
        return v;
    endfunction

    task automatic t_split();
        logic [23:0] ad [7] = '{24'hFF_B000, 24'hFF_B001, 24'hFF_B003, 24'hFF_B002,
                                24'hFF_BFFF, 24'h00_0004, 24'h00_0009};
        cmad_pkg::cmad_size_t sz [7] = '{cmad_pkg::SZ_QUAD, cmad_pkg::SZ_QUAD, cmad_pkg::SZ_WORD,
            cmad_pkg::SZ_WORD, cmad_pkg::SZ_BYTE, cmad_pkg::SZ_QUAD, cmad_pkg::SZ_WORD};
        logic [11:0] e;
        int nb;
        for (int i = 0; i < 7; i++) begin
            nb = 1 << int'(sz[i]);
            e = exp_be(ad[i], nb);
            acc(ad[i], sz[i], 1'b0, 32'h0);
            check("read data", exp_rd(ad[i][23] ? 8'h3C : 8'hA5, ad[i], nb), rd);
            check("part count", 32'(e[11:8]), 32'(nStrobe));
            check("lane log", 32'(e[7:0]), 32'(beLog));
            check("stall span", 32'(e[11:8]), 32'(lat));
        end
        $display("test split done");
    endtask

    task automatic t_write();
        acc(24'hFF_B041, cmad_pkg::SZ_QUAD, 1'b1, 32'h1122_3344);
        check("write lanes", 32'h0000_001E, 32'(beLog));
        check("ram bytes", 32'h1122_3344, {cmad_mem_model_inst_ram.peek(8'h41),
            cmad_mem_model_inst_ram.peek(8'h42), cmad_mem_model_inst_ram.peek(8'h43),
            cmad_mem_model_inst_ram.peek(8'h44)});
        acc(24'hFF_B041, cmad_pkg::SZ_QUAD, 1'b0, 32'h0);
        check("read back", 32'h1122_3344, rd);
        $display("test write done");
    endtask

    task automatic t_ctrl();
        // the read-write registers and the unmapped byte after the flags register are touched here
        acc(cmad_pkg::PC_LIMIT_ADDR, cmad_pkg::SZ_QUAD, 1'b1, 32'h1234_5678);
        check("pc limit", 32'h1234_5678, pcLimit);
        acc(cmad_pkg::SP_LIMIT_ADDR, cmad_pkg::SZ_QUAD, 1'b1, 32'hCAFE_F00D);
        check("sp limit", 32'hCAFE_F00D, spLimit);
        acc(cmad_pkg::FLAGS_ADDR, cmad_pkg::SZ_BYTE, 1'b1, 32'h3C);
        check("flags", 32'h3C, 32'(cpuFlags));
        acc(cmad_pkg::CONTROL_ADDR, cmad_pkg::SZ_BYTE, 1'b1, 32'h5A);
        check("control", 32'h5A, 32'(cpuControl));
        acc(cmad_pkg::FLAGS_ADDR, cmad_pkg::SZ_WORD, 1'b0, 32'h0);
        check("flags word", 32'h3CFF, rd);
        acc(cmad_pkg::PC_LIMIT_ADDR, cmad_pkg::SZ_QUAD, 1'b0, 32'h0);
        check("pc limit read", 32'h1234_5678, rd);
        check("no external part", 32'h0, 32'(nStrobe));
        $display("test ctrl done");
    endtask

    task automatic t_unmapped();
        acc(24'hFF_E000, cmad_pkg::SZ_WORD, 1'b0, 32'h0);
        check("hole read", 32'hFFFF, rd);
        acc(24'hFF_E011, cmad_pkg::SZ_BYTE, 1'b1, 32'hAA);
        check("hole write", 32'h3C5A, {16'h0, cpuFlags, cpuControl});
        acc(24'hFF_AFFF, cmad_pkg::SZ_BYTE, 1'b0, 32'h0);
        check("below ram", 32'hFF, rd);
        acc(24'hFF_AFFF, cmad_pkg::SZ_BYTE, 1'b1, 32'h77);
        check("gap write parts", 32'h0, 32'(nStrobe));
        acc(24'h80_0000, cmad_pkg::SZ_QUAD, 1'b0, 32'h0);
        check("gap read", 32'hFFFF_FFFF, rd);
        acc(24'hFF_E102, cmad_pkg::SZ_BYTE, 1'b1, 32'hC3);
        acc(24'hFF_E101, cmad_pkg::SZ_WORD, 1'b0, 32'h0);
        check("narrow periph", 32'h68C3, rd);
        check("narrow parts", 32'h2, 32'(nStrobe));
        acc(24'hFF_E0A2, cmad_pkg::SZ_BYTE, 1'b0, 32'h0);
        check("missing periph", 32'hFF, rd);
        acc(24'hFF_F000, cmad_pkg::SZ_WORD, 1'b0, 32'h0);
        check("wide hole read", 32'hFFFF, rd);
        check("wide periph lanes", 32'h03, 32'(beLog));
        $display("test unmapped done");
    endtask

    // reset in mid-run: registers return to their reset values, access resumes
    task automatic t_reset();
        @(posedge clock);
        rst_n <= 1'b0;
        @(posedge clock);
        check("pc limit again", cmad_pkg::PC_LIMIT_RST, pcLimit);
        check("flags again", 32'(cmad_pkg::FLAGS_RST), 32'(cpuFlags));
        check("ready again", 32'h0, 32'(cpuReady));
        rst_n <= 1'b1;
        acc(24'hFF_B002, cmad_pkg::SZ_WORD, 1'b0, 32'h0);
        check("after reset", exp_rd(8'h3C, 24'hFF_B002, 2), rd);
        $display("test mid reset done");
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, nErrors);
        if (nErrors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        nErrors++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge clock);
        check("ready in reset", 32'h0, 32'(cpuReady));
        check("pc limit reset", cmad_pkg::PC_LIMIT_RST, pcLimit);
        rst_n <= 1'b1;
        $display("test reset done");
        t_split();
        t_write();
        t_ctrl();
        t_unmapped();
        t_reset();
        final_report();
    end
endmodule
